// *** verilog/frt2_top.sv ***
// Free running timer two: 16-bit counter, prescaler, overflow flags
// Function
// R1: 16-bit up-counter readable as two bytes
// R2: Source off, oscillator/12, or external edges
// R3: Sample count input twice; low-high is edge
// R4: At most one external count per cycle
// R5: Early edge counts next cycle, else later
// R6: Source holds low, high half cycle each
// R7: Prescaler divides by 1, 2, 4, 8
// R8: Prescaler cleared on selection change, reset
// R9: Bytes readable live; no latch, no load
// R10: Clear on reset or enabled external edge
// R11: External reset clears prescaler too
// R12: Overflow flags set one cycle after overflow
// R13: Word overflow also sets byte flag
// R14: Byte flag at control register bit 4
// R15: Byte interrupt needs enable and select
// R16: Word interrupt needs enable and select
// R17: Both requests share one interrupt output
// R18: Flags cleared only by software, individually
// R19: Idle holds counter and prescaler reset
// R20: Source and divide-by-eight encodings
// R21: Wrap from all ones sets flags
`timescale 1ns/1ns
module frt2_top
	import frt2_pkg::*;
(
	input  wire logic              core_clk,
	input  wire logic              reset,
	input  wire logic              idle_mode,
	input  wire frt2_cfg_t         cfg,
	input  wire logic              timer_interrupt_enable,
	input  wire frt2_clr_t         flag_clear,
	input  wire logic              external_count_input,
	input  wire logic              external_timer_reset_input,
	output frt2_count_t            count,
	output logic                   byte_overflow_flag,
	output logic                   word_overflow_flag,
	output logic [7:0]             timer_control_register,
	output logic [7:0]             timer_flag_register,
	output logic                   timer_irq
);

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------
	function automatic logic [2:0] frt2_div_mask(input logic [1:0] sel);
		logic [2:0] m;
		m = FRT2_PRE_ZERO;
		unique case (sel)
			FRT2_DIV_1: m = 3'h0;
			FRT2_DIV_2: m = 3'h1;
			FRT2_DIV_4: m = 3'h3;
			FRT2_DIV_8: m = 3'h7;                             // [R20]
		endcase
		return m;
	endfunction

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [3:0]    phase_reg;
	logic [3:0]    phase_next;
	logic [2:0]    pre_reg;
	logic [2:0]    pre_next;
	logic [15:0]   cnt_reg;
	logic [15:0]   cnt_next;
	logic [1:0]    src_reg;
	logic [1:0]    src_next;
	logic [1:0]    div_reg;
	logic [1:0]    div_next;
	logic          rst_in_reg;
	logic          rst_in_next;
	logic          byte_ovf_reg;
	logic          byte_ovf_next;
	logic          word_ovf_reg;
	logic          word_ovf_next;
	logic          bflag_reg;
	logic          bflag_next;
	logic          wflag_reg;
	logic          wflag_next;
	logic          irq_reg;
	logic          irq_next;
	logic [7:0]    con_reg;
	logic [7:0]    con_next;
	logic [7:0]    fr_reg;
	logic [7:0]    fr_next;
	logic [15:0]   out_reg;
	logic [15:0]   out_next;
	logic          ext_edge;
	logic          tick;
	logic          pre_tick;
	logic          clr_all;
	logic          ext_rst;
	logic          sel_change;
	logic          cycle_end;
	logic [2:0]    mask;

	// ------------------------------------------------------------
	// External count edge detector
	// ------------------------------------------------------------
	frt2_edge i_frt2_edge (
		.core_clk             (core_clk),
		.reset                (reset),
		.clear                (clr_all),
		.phase                (phase_reg),
		.external_count_input (external_count_input),
		.edge_pulse           (ext_edge)
	);

	// ------------------------------------------------------------
	// Machine cycle phase
	// ------------------------------------------------------------
	assign cycle_end = (phase_reg == FRT2_PHASE_LAST);

	always_comb
	begin
		if (cycle_end)
			phase_next = FRT2_PHASE_ZERO;
		else
			phase_next = phase_reg + FRT2_PHASE_ONE;
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
			phase_reg <= FRT2_PHASE_ZERO;
		else
			phase_reg <= phase_next;
	end

	// ------------------------------------------------------------
	// Selection history and reset pin edge
	// ------------------------------------------------------------
	// A selection change is seen against last cycle's selection
	assign sel_change = (cfg.source_select != src_reg)
		|| (cfg.prescale_select != div_reg);
	assign ext_rst = cfg.external_reset_enable && !rst_in_reg
		&& external_timer_reset_input;                       // [R10]
	assign clr_all = idle_mode || ext_rst;                  // [R19] [R11]

	always_comb
	begin
		src_next = cfg.source_select;
		div_next = cfg.prescale_select;
		rst_in_next = external_timer_reset_input;
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			src_reg <= FRT2_SRC_OFF;
			div_reg <= FRT2_DIV_1;
			// Pin history starts high: no false edge after reset
			rst_in_reg <= 1'b1;
		end
		else
		begin
			src_reg <= src_next;
			div_reg <= div_next;
			rst_in_reg <= rst_in_next;
		end
	end

	// ------------------------------------------------------------
	// Prescaler
	// ------------------------------------------------------------
	assign mask = frt2_div_mask(cfg.prescale_select);

	always_comb
	begin
		tick = 1'b0;
		// One prescaler input per machine cycle at most
		unique case (cfg.source_select)
			FRT2_SRC_OSC: tick = cycle_end;                   // [R2] [R20]
			FRT2_SRC_EXT: tick = ext_edge;                    // [R2] [R4]
			default:      tick = 1'b0;                        // [R2]
		endcase
		pre_tick = tick && ((pre_reg & mask) == mask);        // [R7]
		pre_next = pre_reg;
		if (tick)
			pre_next = pre_tick ? FRT2_PRE_ZERO : pre_reg + FRT2_PRE_ONE;
		if (sel_change || clr_all)
			pre_next = FRT2_PRE_ZERO;                         // [R8] [R11]
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
			pre_reg <= FRT2_PRE_ZERO;                         // [R8]
		else
			pre_reg <= pre_next;
	end

	// ------------------------------------------------------------
	// Counter and overflow events
	// ------------------------------------------------------------
	always_comb
	begin
		cnt_next = cnt_reg;
		byte_ovf_next = 1'b0;
		word_ovf_next = 1'b0;
		// The count in a cycle with a new selection is dropped
		if (pre_tick && !sel_change)
		begin
			cnt_next = cnt_reg + FRT2_CNT_ONE;                // [R1] [R21]
			byte_ovf_next = (cnt_reg[FRT2_BYTE_W-1:0]
				== FRT2_BYTE_ALL1);                           // [R12]
			word_ovf_next = (cnt_reg == FRT2_CNT_ALL1);       // [R21]
		end
		if (clr_all)
		begin
			cnt_next = FRT2_CNT_ZERO;                         // [R10] [R19]
			byte_ovf_next = 1'b0;
			word_ovf_next = 1'b0;
		end
		// No holding latch: the output shows the live count
		out_next = cnt_next;                                  // [R9]
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			cnt_reg <= FRT2_CNT_ZERO;                         // [R10]
			byte_ovf_reg <= 1'b0;
			word_ovf_reg <= 1'b0;
			out_reg <= FRT2_CNT_ZERO;
		end
		else
		begin
			cnt_reg <= cnt_next;
			byte_ovf_reg <= byte_ovf_next;
			word_ovf_reg <= word_ovf_next;
			out_reg <= out_next;
		end
	end

	// ------------------------------------------------------------
	// Overflow flags
	// ------------------------------------------------------------
	always_comb
	begin
		bflag_next = bflag_reg;
		wflag_next = wflag_reg;
		if (flag_clear.byte_clear)
			bflag_next = 1'b0;                                // [R18]
		if (flag_clear.word_clear)
			wflag_next = 1'b0;                                // [R18]
		// Set wins over a clear in the same cycle
		if (byte_ovf_reg || word_ovf_reg)
			bflag_next = 1'b1;                                // [R12] [R13]
		if (word_ovf_reg)
			wflag_next = 1'b1;                                // [R12]
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			bflag_reg <= 1'b0;
			wflag_reg <= 1'b0;
		end
		else
		begin
			bflag_reg <= bflag_next;
			wflag_reg <= wflag_next;
		end
	end

	// ------------------------------------------------------------
	// Interrupt request and register images
	// ------------------------------------------------------------
	always_comb
	begin
		irq_next = timer_interrupt_enable
			&& ((bflag_next && cfg.byte_overflow_irq_select)  // [R15]
			|| (wflag_next && cfg.word_overflow_irq_select)); // [R16] [R17]
		// Low nibble mirrors the source and prescaler selection
		con_next = {FRT2_PHASE_ZERO, cfg.source_select,
			cfg.prescale_select};
		con_next[FRT2_CON_WORD_SEL] = cfg.word_overflow_irq_select;
		con_next[FRT2_CON_BYTE_SEL] = cfg.byte_overflow_irq_select;
		con_next[FRT2_CON_EXT_EN] = cfg.external_reset_enable;
		con_next[FRT2_CON_BYTE_FLG] = bflag_next;             // [R14]
		fr_next = 8'h00;
		fr_next[FRT2_FLG_WORD] = wflag_next;                  // [R16]
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			irq_reg <= 1'b0;
			con_reg <= 8'h00;
			fr_reg <= 8'h00;
		end
		else
		begin
			irq_reg <= irq_next;
			con_reg <= con_next;
			fr_reg <= fr_next;
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign count = out_reg;
	assign byte_overflow_flag = bflag_reg;
	assign word_overflow_flag = wflag_reg;
	assign timer_control_register = con_reg;
	assign timer_flag_register = fr_reg;
	assign timer_irq = irq_reg;

endmodule

// *** verilog/frt2_pkg.sv ***
// Package: constants and carrier types for the free running timer two
package frt2_pkg;

	// ------------------------------------------------------------
	// Widths and counts
	// ------------------------------------------------------------
	localparam int unsigned   FRT2_CNT_W       = 16;
	localparam int unsigned   FRT2_BYTE_W      = 8;
	localparam int unsigned   FRT2_PRE_W       = 3;
	localparam int unsigned   FRT2_PHASE_W     = 4;
	// Last phase of a machine cycle of 12 oscillator periods
	localparam logic [3:0]    FRT2_PHASE_LAST  = 4'hb;
	// Phases of the two sampling points (S2P1, S5P1)
	localparam logic [3:0]    FRT2_SAMPLE_A    = 4'h2;
	localparam logic [3:0]    FRT2_SAMPLE_B    = 4'h8;
	localparam logic [15:0]   FRT2_CNT_ZERO    = 16'h0000;
	localparam logic [15:0]   FRT2_CNT_ONE     = 16'h0001;
	localparam logic [15:0]   FRT2_CNT_ALL1    = 16'hffff;
	localparam logic [7:0]    FRT2_BYTE_ALL1   = 8'hff;
	localparam logic [2:0]    FRT2_PRE_ZERO    = 3'h0;
	localparam logic [2:0]    FRT2_PRE_ONE     = 3'h1;
	localparam logic [3:0]    FRT2_PHASE_ZERO  = 4'h0;
	localparam logic [3:0]    FRT2_PHASE_ONE   = 4'h1;

	// ------------------------------------------------------------
	// Control, flag and interrupt enable register bit positions
	// ------------------------------------------------------------
	localparam int unsigned   FRT2_CON_WORD_SEL = 7;
	localparam int unsigned   FRT2_CON_BYTE_SEL = 6;
	localparam int unsigned   FRT2_CON_EXT_EN   = 5;
	localparam int unsigned   FRT2_CON_BYTE_FLG = 4;
	localparam int unsigned   FRT2_FLG_WORD     = 7;
	localparam int unsigned   FRT2_IEN_TIMER    = 7;

	// ------------------------------------------------------------
	// Clock source and prescaler encodings
	// ------------------------------------------------------------
	localparam logic [1:0]    FRT2_SRC_OFF     = 2'h0;
	localparam logic [1:0]    FRT2_SRC_OSC     = 2'h1;
	localparam logic [1:0]    FRT2_SRC_EXT     = 2'h2;
	localparam logic [1:0]    FRT2_DIV_1       = 2'h0;
	localparam logic [1:0]    FRT2_DIV_2       = 2'h1;
	localparam logic [1:0]    FRT2_DIV_4       = 2'h2;
	localparam logic [1:0]    FRT2_DIV_8       = 2'h3;

	// ------------------------------------------------------------
	// Carrier types
	// ------------------------------------------------------------
	typedef struct packed {
		logic       word_overflow_irq_select;
		logic       byte_overflow_irq_select;
		logic       external_reset_enable;
		logic [1:0] source_select;      // {high, low}
		logic [1:0] prescale_select;    // {high, low}
	} frt2_cfg_t;

	typedef struct packed {
		logic byte_clear;
		logic word_clear;
	} frt2_clr_t;

	typedef struct packed {
		logic [7:0] timer_high_byte;
		logic [7:0] timer_low_byte;
	} frt2_count_t;

endpackage

// *** verilog/frt2_edge.sv ***
// Edge detector: samples the count input twice per machine cycle
`timescale 1ns/1ns
module frt2_edge
	import frt2_pkg::*;
(
	input  wire logic              core_clk,
	input  wire logic              reset,
	input  wire logic              clear,
	input  wire logic [3:0]        phase,
	input  wire logic              external_count_input,
	output logic                   edge_pulse
);

	logic   sample_reg;
	logic   sample_next;
	logic   pend_reg;
	logic   pend_next;
	logic   late_reg;
	logic   late_next;
	logic   edge_reg;
	logic   edge_next;
	logic   seen;
	logic   at_a;
	logic   at_b;

	assign at_a = (phase == FRT2_SAMPLE_A);
	assign at_b = (phase == FRT2_SAMPLE_B);
	assign edge_pulse = edge_reg;

	always_comb
	begin
		sample_next = sample_reg;
		pend_next = pend_reg;
		late_next = late_reg;
		edge_next = 1'b0;
		seen = 1'b0;
		if (at_a || at_b)
		begin
			sample_next = external_count_input;
			seen = !sample_reg && external_count_input;       // [R3]
		end
		// Edge at the first point counts in the next machine cycle,
		// at the second point one machine cycle after that
		if (phase == FRT2_PHASE_LAST)
		begin
			edge_next = pend_reg;                             // [R5]
			pend_next = late_reg;
			late_next = 1'b0;
		end
		if (seen && at_a)
			pend_next = 1'b1;                                 // [R5]
		if (seen && at_b)
			late_next = 1'b1;                                 // [R5]
		if (clear)
		begin
			pend_next = 1'b0;
			late_next = 1'b0;
			edge_next = 1'b0;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (reset)
		begin
			sample_reg <= 1'b1;
			pend_reg <= 1'b0;
			late_reg <= 1'b0;
			edge_reg <= 1'b0;
		end
		else
		begin
			sample_reg <= sample_next;
			pend_reg <= pend_next;
			late_reg <= late_next;
			edge_reg <= edge_next;
		end
	end

endmodule

// *** bench/frt2_sva.sv ***
// Checker: port-level properties of the free running timer two
`timescale 1ns/1ns
module frt2_sva
	import frt2_pkg::*;
(
	input wire logic        core_clk,
	input wire logic        reset,
	input wire logic        idle_mode,
	input wire frt2_cfg_t   cfg,
	input wire logic        timer_interrupt_enable,
	input wire frt2_clr_t   flag_clear,
	input wire logic        external_count_input,
	input wire logic        external_timer_reset_input,
	input wire frt2_count_t count,
	input wire logic        byte_overflow_flag,
	input wire logic        word_overflow_flag,
	input wire logic [7:0]  timer_control_register,
	input wire logic [7:0]  timer_flag_register,
	input wire logic        timer_irq
);
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (reset);

	property p_irq;
		$stable(cfg) && $stable(timer_interrupt_enable) |->
			timer_irq == (timer_interrupt_enable &&
			(byte_overflow_flag && cfg.byte_overflow_irq_select ||
			word_overflow_flag && cfg.word_overflow_irq_select));
	endproperty
	property p_ctrl;
		!$past(reset) |-> timer_control_register ==
			{$past(cfg[6:4]), byte_overflow_flag, $past(cfg[3:0])};
	endproperty
	property p_flags;
		timer_flag_register == {word_overflow_flag, 7'h00};
	endproperty
	property p_hold;
		$fell(byte_overflow_flag) |-> $past(flag_clear.byte_clear);
	endproperty
	property p_idle;
		idle_mode ##1 idle_mode |=> count == FRT2_CNT_ZERO;
	endproperty
	property p_step;
		count != $past(count) |->
			count == $past(count) + FRT2_CNT_ONE || count == FRT2_CNT_ZERO;
	endproperty
	property p_byte_set;
		count.timer_low_byte == 8'h00 &&
			count == $past(count) + FRT2_CNT_ONE |=> byte_overflow_flag;
	endproperty
	property p_off;
		(cfg.source_select == FRT2_SRC_OFF && !idle_mode &&
			!cfg.external_reset_enable) [*4] |-> $stable(count);
	endproperty

	a_irq: assert property (p_irq)
		else $error("irq level wrong");
	a_ctrl: assert property (p_ctrl)
		else $error("control register wrong");
	a_flags: assert property (p_flags)
		else $error("flag register wrong");
	a_hold: assert property (p_hold)
		else $error("byte flag cleared without request");
	a_idle: assert property (p_idle)
		else $error("count not held in idle");
	a_step: assert property (p_step)
		else $error("count jumped");
	a_byte_set: assert property (p_byte_set)
		else $error("byte flag late");
	a_off: assert property (p_off)
		else $error("count moved while off");

	c_irq: cover property (byte_overflow_flag && timer_irq);
	c_idle: cover property (idle_mode ##1 idle_mode);
	c_clear: cover property ($fell(byte_overflow_flag));
endmodule

// *** bench/frt2_pulse_src.sv ***
// Partner model: external pulse source for count and reset pins
`timescale 1ns/1ns
module frt2_pulse_src
(
	input  wire logic core_clk,
	output logic      cnt_pin,
	output logic      rst_pin
);
	initial
	begin
		cnt_pin = 1'b0;
		rst_pin = 1'b0;
	end

	// Low for half clocks, then high; half of 6 meets the minimum
	task automatic pulses(input int n, input int half);
		repeat (n)
		begin
			repeat (half) @(posedge core_clk);
			cnt_pin <= 1'b1;
			repeat (half) @(posedge core_clk);
			cnt_pin <= 1'b0;
		end
	endtask

	task automatic rst_pulse();
		repeat (6) @(posedge core_clk);
		rst_pin <= 1'b1;
		repeat (6) @(posedge core_clk);
		rst_pin <= 1'b0;
	endtask
endmodule

// *** bench/tb_frt2_top.sv ***
// Testbench: directed sequences for the free running timer two
`timescale 1ns/1ns
`define CHK(n, e, g) chk(n, 40'(e), 40'(g))
module tb_frt2_top
	import frt2_pkg::*;
;
	logic        core_clk = 1'b0;
	logic        reset = 1'b1;
	logic        idle_mode = 1'b0;
	frt2_cfg_t   cfg = '0;
	logic        timer_interrupt_enable = 1'b0;
	frt2_clr_t   flag_clear = '0;
	logic        external_count_input;
	logic        external_timer_reset_input;
	frt2_count_t count;
	logic        byte_overflow_flag;
	logic        word_overflow_flag;
	logic [7:0]  timer_control_register;
	logic [7:0]  timer_flag_register;
	logic        timer_irq;
	frt2_count_t c0;
	int          err_total = 0;
	int          comparisons = 0;
	int          cyc = 0;
	int          k;

	always #25 core_clk = ~core_clk;

	frt2_pulse_src i_frt2_pulse_src (
		.core_clk (core_clk),
		.cnt_pin  (external_count_input),
		.rst_pin  (external_timer_reset_input)
	);

	frt2_top i_frt2_top (
		.core_clk                   (core_clk),
		.reset                      (reset),
		.idle_mode                  (idle_mode),
		.cfg                        (cfg),
		.timer_interrupt_enable     (timer_interrupt_enable),
		.flag_clear                 (flag_clear),
		.external_count_input       (external_count_input),
		.external_timer_reset_input (external_timer_reset_input),
		.count                      (count),
		.byte_overflow_flag         (byte_overflow_flag),
		.word_overflow_flag         (word_overflow_flag),
		.timer_control_register     (timer_control_register),
		.timer_flag_register        (timer_flag_register),
		.timer_irq                  (timer_irq)
	);

	task automatic chk(input string n, input logic [39:0] e, g);
		comparisons++;
		if (g !== e)
		begin
			err_total++;
			$display("mismatch %s expected %h seen %h", n, e, g);
		end
	endtask

	task automatic cycles(input int n);
		repeat (n) @(negedge core_clk);
	endtask

	// New settings, then time for the count pipeline to settle
	task automatic put(input frt2_cfg_t c);
		@(posedge core_clk);
		cfg <= c;
		cycles(30);
	endtask

	task automatic wait_chg();
		c0 = count;
		for (k = 0; k < 200 && count === c0; k++)
			@(negedge core_clk);
		c0 = count;
	endtask

	task automatic drive_clear(input frt2_clr_t c);
		@(posedge core_clk);
		flag_clear <= c;
		@(posedge core_clk);
		flag_clear <= '0;
		cycles(1);
	endtask

	task automatic wrap_up();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	always @(posedge core_clk)
	begin
		cyc++;
		if (cyc == 12000)
		begin
			err_total++;
			wrap_up();
		end
	end

	initial
	begin
		repeat (8) @(posedge core_clk);
		reset <= 1'b0;
		cycles(4);
		`CHK("reset outputs", 0, {count, timer_irq, timer_flag_register});
		for (int d = 0; d < 4; d++)
		begin
			put('{1'b0, 1'b0, 1'b0, FRT2_SRC_OSC, 2'(d)});
			wait_chg();
			cycles(48 << d);
			`CHK("osc rate", c0 + 16'h4, count);
		end
		put('{1'b0, 1'b0, 1'b0, FRT2_SRC_EXT, FRT2_DIV_1});
		c0 = count;
		i_frt2_pulse_src.pulses(5, 6);
		cycles(40);
		`CHK("ext count", c0 + 16'h5, count);
		c0 = count;
		i_frt2_pulse_src.pulses(12, 4);
		cycles(40);
		`CHK("ext max rate", 1, count - c0 <= 16'ha);
		put('{1'b0, 1'b0, 1'b0, FRT2_SRC_EXT, FRT2_DIV_2});
		c0 = count;
		i_frt2_pulse_src.pulses(6, 6);
		cycles(40);
		`CHK("ext divide 2", c0 + 16'h3, count);
		put('{1'b0, 1'b0, 1'b0, FRT2_SRC_EXT, FRT2_DIV_4});
		c0 = count;
		i_frt2_pulse_src.rst_pulse();
		cycles(10);
		`CHK("reset pin disabled", c0, count);
		put('{1'b0, 1'b0, 1'b1, FRT2_SRC_EXT, FRT2_DIV_4});
		i_frt2_pulse_src.pulses(3, 6);
		i_frt2_pulse_src.rst_pulse();
		cycles(10);
		`CHK("reset pin", 0, count);
		i_frt2_pulse_src.pulses(2, 6);
		cycles(40);
		`CHK("prescaler cleared", 0, count);
		i_frt2_pulse_src.pulses(2, 6);
		cycles(40);
		`CHK("prescaler count", 1, count);
		put('{1'b0, 1'b0, 1'b0, FRT2_SRC_OSC, FRT2_DIV_1});
		@(posedge core_clk);
		idle_mode <= 1'b1;
		cycles(40);
		`CHK("idle count", 0, count);
		@(posedge core_clk);
		idle_mode <= 1'b0;
		put('{1'b0, 1'b1, 1'b0, FRT2_SRC_OSC, FRT2_DIV_1});
		for (k = 0; k < 3400 && byte_overflow_flag !== 1'b1; k++)
			@(negedge core_clk);
		`CHK("byte wrap", 16'h0100, count);
		`CHK("control register", 8'h54, timer_control_register);
		`CHK("irq disabled", 0, {timer_irq, timer_flag_register});
		`CHK("no word flag", 0, word_overflow_flag);
		@(posedge core_clk);
		timer_interrupt_enable <= 1'b1;
		cycles(2);
		`CHK("byte irq", 1, timer_irq);
		put('{1'b1, 1'b0, 1'b0, FRT2_SRC_OSC, FRT2_DIV_1});
		`CHK("word select only", 0, timer_irq);
		drive_clear('{1'b0, 1'b1});
		`CHK("word clear", 1, byte_overflow_flag);
		drive_clear('{1'b1, 1'b0});
		`CHK("byte clear", 0, byte_overflow_flag);
		@(posedge core_clk);
		reset <= 1'b1;
		cycles(2);
		`CHK("second reset", 0, count);
		wrap_up();
	end
endmodule

bind frt2_top frt2_sva i_frt2_sva (
	.core_clk                   (core_clk),
	.reset                      (reset),
	.idle_mode                  (idle_mode),
	.cfg                        (cfg),
	.timer_interrupt_enable     (timer_interrupt_enable),
	.flag_clear                 (flag_clear),
	.external_count_input       (external_count_input),
	.external_timer_reset_input (external_timer_reset_input),
	.count                      (count),
	.byte_overflow_flag         (byte_overflow_flag),
	.word_overflow_flag         (word_overflow_flag),
	.timer_control_register     (timer_control_register),
	.timer_flag_register        (timer_flag_register),
	.timer_irq                  (timer_irq)
);
